// file: tb/eied_pin_src.sv
// Partner model: signal sources that drive the interrupt pins
`timescale 1ns/1ps
module eied_pin_src (
  input wire logic hclk,
  input wire logic [8:0] lvl,
  output logic [8:0] pins
);
  // ****
  // Pin drivers
  // ****
  // Sources hold a level until told otherwise; short pulses model noise
  always @(posedge hclk) pins <= lvl;
endmodule

// file: tb/eied_top_checker.sv
// Checker: bus timing, request pulses and filter spacing of the edge detector
`timescale 1ns/1ps
module eied_top_checker #(
  parameter int FILT_CYC = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic nmi_in,
  input wire logic ext_irq_in_0,
  input wire logic nmi_req,
  input wire logic irq_req_0,
  input wire logic nmi_wake
);
  // ****
  // Quiet counters
  // ****
  // Cycles since ext_irq_in_0 and nmi_in last changed, saturating
  logic [3:0] q0, qn;
  logic p0, pn;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q0 <= 4'h0;
      qn <= 4'h0;
      p0 <= 1'b0;
      pn <= 1'b0;
    end else begin
      p0 <= ext_irq_in_0;
      pn <= nmi_in;
      q0 <= (ext_irq_in_0 != p0) ? 4'h0 : ((q0 == 4'hf) ? q0 : q0 + 4'h1);
      qn <= (nmi_in != pn) ? 4'h0 : ((qn == 4'hf) ? qn : qn + 4'h1);
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hresp == 2'h0)
    else $error("response not okay");
  read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=>
    hreadyout) else $error("write stalled");
  reset_quiet_a: assert property ($rose(hresetn) |->
    hreadyout && hrdata == 32'h0 && !nmi_req && !irq_req_0) else $error("bad reset state");
  req_pulse_a: assert property (irq_req_0 |=> !irq_req_0)
    else $error("request longer than one cycle");
  nmi_pulse_a: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request longer than one cycle");
  filter_min_a: assert property (irq_req_0 |-> q0 >= 4'(FILT_CYC + 1))
    else $error("request without persistence");
  req_cause_a: assert property (irq_req_0 |-> q0 <= 4'h8)
    else $error("request without pin edge");
  nmi_cause_a: assert property (nmi_req |-> qn <= 4'h8)
    else $error("nmi request without pin edge");
  wake_stop_a: assert property (nmi_wake |-> nmi_req && $past(stop_mode))
    else $error("wake outside stop");
endmodule
bind eied_top eied_top_checker #(.FILT_CYC(FILT_CYC)) chk_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .stop_mode, .nmi_in, .ext_irq_in_0, .nmi_req,
  .irq_req_0, .nmi_wake);

// file: tb/testbench.sv
// Testbench: register map, edge codes, filter, stop wake and reset of the edge detector
`timescale 1ns/1ps
module testbench;
  import eied_pkg::*;
  typedef struct packed {
    logic [31:0] fi;
    logic [31:0] ri;
    logic [4:0] b;
    logic [3:0] c;
    logic [1:0] code;
  } eied_row_type;
  // ****
  // Rows: select registers, bit, pin cell, edge code
  // ****
  localparam eied_row_type ROWS [9] = '{
    '{FALL_A_IDX, RISE_A_IDX, 5'h2, 4'h0, 2'h1}, '{FALL_A_IDX, RISE_A_IDX, 5'h3, 4'h1, 2'h2},
    '{FALL_A_IDX, RISE_A_IDX, 5'h4, 4'h2, 2'h3}, '{FALL_A_IDX, RISE_A_IDX, 5'h5, 4'h3, 2'h0},
    '{FALL_A_IDX, RISE_A_IDX, 5'h6, 4'h4, 2'h1}, '{FALL_C_IDX, RISE_C_IDX, 5'h1, 4'h5, 2'h2},
    '{FALL_C_IDX, RISE_C_IDX, 5'h9, 4'h6, 2'h3}, '{FALL_B_IDX, RISE_B_IDX, 5'h0, 4'h7, 2'h1},
    '{FALL_B_IDX, RISE_B_IDX, 5'h1, 4'h8, 2'h3}};
  localparam logic [31:0] REGS [10] = '{FALL_A_IDX, RISE_A_IDX, FALL_B_IDX, RISE_B_IDX,
    PORT_MODE_IDX, FALL_C_IDX, FALL_C_HIGH_IDX, RISE_C_IDX, RISE_C_HIGH_IDX, 32'h0000_0010};
  localparam int LIMIT = 6000;
  logic hclk, hresetn, hsel, hwrite, stop_mode;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, d, base;
  logic [8:0] lvl;
  wire logic [8:0] pins;
  wire logic [9:0] req;
  wire logic hreadyout;
  wire logic [1:0] hresp;
  wire logic [31:0] hrdata;
  logic [31:0] cnt [10];
  eied_row_type r;
  int n_mismatch, check_count, cyc;
  eied_pin_src src (.hclk(hclk), .lvl(lvl), .pins(pins));
  eied_top #(.FILT_CYC(3)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .nmi_in(pins[0]), .ext_irq_in_0(pins[1]), .ext_irq_in_1(pins[2]), .ext_irq_in_2(pins[3]),
    .ext_irq_in_3(pins[4]), .ext_irq_in_7(pins[5]), .ext_irq_in_8(pins[6]),
    .ext_irq_in_9(pins[7]), .ext_irq_in_10(pins[8]), .nmi_req(req[0]), .irq_req_0(req[1]),
    .irq_req_1(req[2]), .irq_req_2(req[3]), .irq_req_3(req[4]), .irq_req_7(req[5]),
    .irq_req_8(req[6]), .irq_req_9(req[7]), .irq_req_10(req[8]), .nmi_wake(req[9]));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Pulse counters clear on reset, so compare against a base taken per test
  always @(posedge hclk or negedge hresetn) begin
    for (int k = 0; k < 10; k++) cnt[k] <= hresetn ? cnt[k] + 32'(req[k]) : 32'h0;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic xfer(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx[29:0], 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Long hold so the filter and request pulse settle before the next step
  task automatic pin(input int c, input logic v);
    lvl[c] <= v;
    repeat (12) @(posedge hclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stop_mode = 1'b0;
    lvl = 9'h000;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, PORT_MODE_IDX, 32'h4);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      base = cnt[r.c];
      xfer(1'b1, r.fi, 32'(r.code[1]) << r.b);
      xfer(1'b1, r.ri, 32'(r.code[0]) << r.b);
      xfer(1'b0, r.ri, 32'h0);
      chk(d, 32'(r.code[0]) << r.b);
      pin(r.c, 1'b1);
      pin(r.c, 1'b0);
      chk(cnt[r.c] - base, 32'(r.code[0]) + 32'(r.code[1]));
      xfer(1'b1, r.fi, 32'h0);
      xfer(1'b1, r.ri, 32'h0);
    end
    xfer(1'b1, FALL_C_IDX, 32'hffff_ffff);
    xfer(1'b0, FALL_C_IDX, 32'h0);
    chk(d, 32'h0000_0202);
    xfer(1'b0, FALL_C_HIGH_IDX, 32'h0);
    chk(d, 32'h0000_0002);
    xfer(1'b1, FALL_C_HIGH_IDX, 32'h0);
    xfer(1'b0, FALL_C_IDX, 32'h0);
    chk(d, 32'h0000_0002);
    xfer(1'b1, FALL_C_IDX, 32'h0);
    // Two-cycle noise pulse must vanish in the filter
    xfer(1'b1, RISE_A_IDX, 32'h8);
    base = cnt[1];
    lvl[1] <= 1'b1;
    repeat (2) @(posedge hclk);
    pin(1, 1'b0);
    chk(cnt[1] - base, 32'h0);
    xfer(1'b1, RISE_A_IDX, 32'h4);
    base = cnt[9];
    stop_mode <= 1'b1;
    pin(0, 1'b1);
    chk(cnt[9] - base, 32'h1);
    stop_mode <= 1'b0;
    pin(0, 1'b0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (REGS[i]) begin
      xfer(1'b0, REGS[i], 32'h0);
      chk(d, 32'h0);
    end
    xfer(1'b1, PORT_MODE_IDX, 32'h4);
    pin(0, 1'b1);
    xfer(1'b0, PIN_LEVEL_IDX, 32'h0);
    chk(d, 32'h0000_0001);
    pin(0, 1'b0);
    chk(cnt[0], 32'h0);
    end_of_test();
  end
endmodule

// file: verilog/eied_edge_cell.sv
// One input pin: synchroniser, persistence filter and valid-edge request
`timescale 1ns/1ps
module eied_edge_cell #(
  parameter int FILT_CYC = eied_pkg::FILTER_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  input wire logic bypass,
  input wire logic fall_sel,
  input wire logic rise_sel,
  output logic edge_req,
  output logic level
);
  import eied_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);

  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic [CW-1:0] cnt_reg;
  logic req_reg;
  logic accept;

  // ************************************************************
  // Synchroniser
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ************************************************************
  // Filter
  // ************************************************************
  // A change counts only after it has stood FILT_CYC cycles, or at once when bypass is set
  assign accept = (sync2_reg != level_reg) && (bypass || cnt_reg == CNT_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      level_reg <= 1'b0;
    end else if (accept) begin
      cnt_reg <= '0;
      level_reg <= sync2_reg;
    end else if (sync2_reg != level_reg) begin
      cnt_reg <= cnt_reg + CW'(1);
    end else begin
      cnt_reg <= '0;
    end
  end

  // ************************************************************
  // Edge decode
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= accept && (sync2_reg ? rise_sel : fall_sel);
    end
  end

  assign edge_req = req_reg;
  assign level = level_reg;

endmodule

// file: verilog/eied_pkg.sv
// Package: register map, field positions, reset values and timing for the edge detector
package eied_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_NS = 60;
  // Least persistence time, rounded up to whole cycles
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [31:0] FALL_A_IDX = 32'h0000_0000;
  localparam logic [31:0] RISE_A_IDX = 32'h0000_0001;
  localparam logic [31:0] FALL_B_IDX = 32'h0000_0002;
  localparam logic [31:0] RISE_B_IDX = 32'h0000_0003;
  localparam logic [31:0] PORT_MODE_IDX = 32'h0000_0004;
  localparam logic [31:0] PIN_LEVEL_IDX = 32'h0000_0005;
  localparam logic [31:0] FALL_C_IDX = 32'h0fff_fc06;
  localparam logic [31:0] FALL_C_HIGH_IDX = 32'h0fff_fc07;
  localparam logic [31:0] RISE_C_IDX = 32'h0fff_fc26;
  localparam logic [31:0] RISE_C_HIGH_IDX = 32'h0fff_fc27;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int NMI_SEL_BIT = 2;
  localparam int IN0_SEL_BIT = 3;
  localparam int IN9_SEL_BIT = 0;
  localparam int IN10_SEL_BIT = 1;
  localparam int IN7_SEL_BIT = 1;
  localparam int IN8_SEL_BIT = 9;
  localparam int NMI_FUNC_BIT = 2;
  localparam logic [15:0] SEL_C_MASK = 16'h0202;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] SEL8_RESET = 8'h00;
  localparam logic [15:0] SEL16_RESET = 16'h0000;
  localparam logic [7:0] PORT_MODE_RESET = 8'h00;

  // ************************************************************
  // Bus encodings and pin cells
  // ************************************************************
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // Cell order: nmi, in0..in3, in7, in8, in9, in10
  localparam int NUM_CELLS = 9;

  function automatic logic [31:0] eied_addr(input logic [31:0] idx);
    eied_addr = {idx[29:0], 2'h0};
  endfunction

endpackage

// file: verilog/eied_top.sv
// External interrupt edge detector with AHB-Lite register slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module eied_top #(
  parameter int FILT_CYC = eied_pkg::FILTER_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic nmi_in,
  input wire logic ext_irq_in_0,
  input wire logic ext_irq_in_1,
  input wire logic ext_irq_in_2,
  input wire logic ext_irq_in_3,
  input wire logic ext_irq_in_7,
  input wire logic ext_irq_in_8,
  input wire logic ext_irq_in_9,
  input wire logic ext_irq_in_10,
  output logic nmi_req,
  output logic irq_req_0,
  output logic irq_req_1,
  output logic irq_req_2,
  output logic irq_req_3,
  output logic irq_req_7,
  output logic irq_req_8,
  output logic irq_req_9,
  output logic irq_req_10,
  output logic nmi_wake
);
  import eied_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] fall_sel_a_reg;
  logic [7:0] rise_sel_a_reg;
  logic [7:0] fall_sel_b_reg;
  logic [7:0] rise_sel_b_reg;
  logic [15:0] fall_sel_c_reg;
  logic [15:0] rise_sel_c_reg;
  logic [7:0] port_mode_a_reg;
  logic nmi_wake_reg;
  logic nmi_req_reg;

  logic ph_valid_reg;
  logic ph_write_reg;
  logic [31:0] ph_addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic [1:0] hresp_reg;
  logic [31:0] rd_mux;
  logic take;
  logic wr_en;
  logic sel_fall_a;
  logic sel_rise_a;
  logic sel_fall_b;
  logic sel_rise_b;
  logic sel_port_mode;
  logic sel_pin_level;
  logic sel_fall_c;
  logic sel_fall_c_high;
  logic sel_rise_c;
  logic sel_rise_c_high;
  logic wr_fall_a;
  logic wr_rise_a;
  logic wr_fall_b;
  logic wr_rise_b;
  logic wr_port_mode;
  logic wr_fall_c;
  logic wr_fall_c_high;
  logic wr_rise_c;
  logic wr_rise_c_high;

  logic [NUM_CELLS-1:0] pins;
  logic [NUM_CELLS-1:0] fsel;
  logic [NUM_CELLS-1:0] rsel;
  logic [NUM_CELLS-1:0] byp;
  logic [NUM_CELLS-1:0] reqs;
  logic [NUM_CELLS-1:0] levels;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
    hit = (a == eied_addr(idx));
  endfunction

  // ************************************************************
  // Bus address phase
  // ************************************************************
  // Only word transfers are decoded; other sizes complete OKAY with no effect
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 32'h0000_0000;
    end else if (hready) begin
      ph_valid_reg <= take && (hsize == HSIZE_WORD);
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr;
    end
  end

  assign wr_en = ph_valid_reg && ph_write_reg;

  // ************************************************************
  // Register decode
  // ************************************************************
  // Address decode is shared by the read mux and the write strobes
  assign sel_fall_a = hit(ph_addr_reg, FALL_A_IDX);
  assign sel_rise_a = hit(ph_addr_reg, RISE_A_IDX);
  assign sel_fall_b = hit(ph_addr_reg, FALL_B_IDX);
  assign sel_rise_b = hit(ph_addr_reg, RISE_B_IDX);
  assign sel_port_mode = hit(ph_addr_reg, PORT_MODE_IDX);
  assign sel_pin_level = hit(ph_addr_reg, PIN_LEVEL_IDX);
  assign sel_fall_c = hit(ph_addr_reg, FALL_C_IDX);
  assign sel_fall_c_high = hit(ph_addr_reg, FALL_C_HIGH_IDX);
  assign sel_rise_c = hit(ph_addr_reg, RISE_C_IDX);
  assign sel_rise_c_high = hit(ph_addr_reg, RISE_C_HIGH_IDX);

  // Pin level register is read-only, so it has no strobe
  assign wr_fall_a = wr_en && sel_fall_a;
  assign wr_rise_a = wr_en && sel_rise_a;
  assign wr_fall_b = wr_en && sel_fall_b;
  assign wr_rise_b = wr_en && sel_rise_b;
  assign wr_port_mode = wr_en && sel_port_mode;
  assign wr_fall_c = wr_en && sel_fall_c;
  assign wr_fall_c_high = wr_en && sel_fall_c_high;
  assign wr_rise_c = wr_en && sel_rise_c;
  assign wr_rise_c_high = wr_en && sel_rise_c_high;

  // ************************************************************
  // Bus data phase
  // ************************************************************
  // Reads take one wait state so the read mux sees any write just done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
    end else if (!hreadyout_reg) begin
      hreadyout_reg <= 1'b1;
    end else if (take && !hwrite) begin
      hreadyout_reg <= 1'b0;
    end
  end

  // Read data loads only in the wait cycle and holds otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (!hreadyout_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= HRESP_OKAY;
    end else begin
      hresp_reg <= HRESP_OKAY;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ph_valid_reg && !ph_write_reg) begin
      if (sel_fall_a) begin
        rd_mux = {24'h000000, fall_sel_a_reg};
      end else if (sel_rise_a) begin
        rd_mux = {24'h000000, rise_sel_a_reg};
      end else if (sel_fall_b) begin
        rd_mux = {24'h000000, fall_sel_b_reg};
      end else if (sel_rise_b) begin
        rd_mux = {24'h000000, rise_sel_b_reg};
      end else if (sel_port_mode) begin
        rd_mux = {24'h000000, port_mode_a_reg};
      end else if (sel_pin_level) begin
        rd_mux = {23'h000000, levels};
      end else if (sel_fall_c) begin
        rd_mux = {16'h0000, fall_sel_c_reg};
      end else if (sel_fall_c_high) begin
        rd_mux = {24'h000000, fall_sel_c_reg[15:8]};
      end else if (sel_rise_c) begin
        rd_mux = {16'h0000, rise_sel_c_reg};
      end else if (sel_rise_c_high) begin
        rd_mux = {24'h000000, rise_sel_c_reg[15:8]};
      end
    end
  end

  // ************************************************************
  // Edge select registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_sel_a_reg <= SEL8_RESET;
    end else if (wr_fall_a) begin
      fall_sel_a_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_sel_a_reg <= SEL8_RESET;
    end else if (wr_rise_a) begin
      rise_sel_a_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_sel_b_reg <= SEL8_RESET;
    end else if (wr_fall_b) begin
      fall_sel_b_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_sel_b_reg <= SEL8_RESET;
    end else if (wr_rise_b) begin
      rise_sel_b_reg <= hwdata[7:0];
    end
  end

  // Unimplemented bits are never stored, so they read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_sel_c_reg <= SEL16_RESET;
    end else if (wr_fall_c) begin
      fall_sel_c_reg <= hwdata[15:0] & SEL_C_MASK;
    end else if (wr_fall_c_high) begin
      fall_sel_c_reg[15:8] <= hwdata[7:0] & SEL_C_MASK[15:8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_sel_c_reg <= SEL16_RESET;
    end else if (wr_rise_c) begin
      rise_sel_c_reg <= hwdata[15:0] & SEL_C_MASK;
    end else if (wr_rise_c_high) begin
      rise_sel_c_reg[15:8] <= hwdata[7:0] & SEL_C_MASK[15:8];
    end
  end

  // ************************************************************
  // Port mode register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_mode_a_reg <= PORT_MODE_RESET;
    end else if (wr_port_mode) begin
      port_mode_a_reg <= hwdata[7:0];
    end
  end

  // ************************************************************
  // Pin cells
  // ************************************************************
  assign pins = {ext_irq_in_10, ext_irq_in_9, ext_irq_in_8, ext_irq_in_7,
                 ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0, nmi_in};

  assign fsel = {fall_sel_b_reg[IN10_SEL_BIT], fall_sel_b_reg[IN9_SEL_BIT],
                 fall_sel_c_reg[IN8_SEL_BIT], fall_sel_c_reg[IN7_SEL_BIT],
                 fall_sel_a_reg[IN0_SEL_BIT+3:IN0_SEL_BIT],
                 fall_sel_a_reg[NMI_SEL_BIT]};
  assign rsel = {rise_sel_b_reg[IN10_SEL_BIT], rise_sel_b_reg[IN9_SEL_BIT],
                 rise_sel_c_reg[IN8_SEL_BIT], rise_sel_c_reg[IN7_SEL_BIT],
                 rise_sel_a_reg[IN0_SEL_BIT+3:IN0_SEL_BIT],
                 rise_sel_a_reg[NMI_SEL_BIT]};

  // System clock is stopped in stop mode, so the non-maskable pin skips the count
  assign byp = {{(NUM_CELLS-1){1'b0}}, stop_mode};

  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    eied_edge_cell #(
      .FILT_CYC(FILT_CYC)
    ) u_cell (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(pins[i]),
      .bypass(byp[i]),
      .fall_sel(fsel[i]),
      .rise_sel(rsel[i]),
      .edge_req(reqs[i]),
      .level(levels[i])
    );
  end

  // ************************************************************
  // Non-maskable request and wake
  // ************************************************************
  // Pin behaves as a port pin until its function is switched on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_req_reg <= 1'b0;
    end else begin
      nmi_req_reg <= reqs[0] && port_mode_a_reg[NMI_FUNC_BIT];
    end
  end

  // Wake only while stopped, so a running core sees the plain request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_wake_reg <= 1'b0;
    end else begin
      nmi_wake_reg <= reqs[0] && port_mode_a_reg[NMI_FUNC_BIT] && stop_mode;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign nmi_req = nmi_req_reg;
  assign nmi_wake = nmi_wake_reg;
  assign irq_req_0 = reqs[1];
  assign irq_req_1 = reqs[2];
  assign irq_req_2 = reqs[3];
  assign irq_req_3 = reqs[4];
  assign irq_req_7 = reqs[5];
  assign irq_req_8 = reqs[6];
  assign irq_req_9 = reqs[7];
  assign irq_req_10 = reqs[8];

endmodule
